// ==== logic/psg_top.sv ====
// PLL, system clock divider and run/sleep/deep-sleep clock gating controller
//
// Behaviour
// - Wide divider field is two bits wider than basic, up to divide by 64.
// - Divisor equals the divider code plus one; all ones gives 64.
// - On the PLL path the VCO clock is halved before the divisor.
// - With bypass and no divider the system clock equals the source clock.
// - Crystal code is translated to PLL settings, readable in a read-only register.
// - Translated settings put the VCO within one percent of its target.
// - PLL is powered down after reset until software enables it.
// - Normal mode drives the PLL output; power-down mode does not.
// - Relock starts on crystal change or power-up; same value rewrite does not.
// - Relock trigger loads 0x1200 into a main-oscillator down counter.
// - PLL is never the system clock before the relock count expires.
// - Enable plus select in one write runs from oscillator until settled.
// - Raw lock flag is pollable and drives a maskable lock interrupt.
// - Run mode clocks core and peripherals enabled in run gating registers.
// - Sleep stops core; peripherals use sleep or run gating per auto gating.
// - Sleep keeps the run mode clock source and frequency.
// - Deep sleep stops core; peripherals use deep or run gating per auto gating.
// - Deep sleep runs from main oscillator or a selected internal oscillator.
// - Deep sleep powers the PLL down and applies the divider override only if the PLL was powered on entry.
// - On wake the clock is restored before stopped clocks are re-enabled.
`timescale 1ns/1ns
`default_nettype none
module psg_top #(
   parameter int NG = 3,
   parameter logic [15:0] RELOCK_COUNT = psg_pkg::RELOCK_LOAD
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic main_osc,
   input wire logic [3:0] osc_tick,
   input wire logic pll_tick,
   input wire logic sleep_req,
   input wire logic deep_sel,
   input wire logic wake_irq,
   output logic sys_clk_en,
   output logic cpu_clk_en,
   output logic [NG*32-1:0] gate_en,
   output logic pll_power_down,
   output logic [7:0] pll_mult,
   output logic pll_sel,
   output logic [1:0] sys_src_sel,
   output logic [5:0] sys_div_code,
   output logic main_osc_power_down,
   output logic int_osc_power_up,
   output logic pll_lock_irq
);
   typedef struct packed {
      psg_pkg::psg_mode_t mode;
      logic ds_pll;
      logic [31:0] cfg;
      logic [31:0] cfg_ext;
      logic [31:0] ds_cfg;
      logic mask;
      logic [NG-1:0][31:0] rg;
      logic [NG-1:0][31:0] sg;
      logic [NG-1:0][31:0] dg;
      logic [15:0] relock;
      logic locked;
      logic pd;
      logic pll;
      logic usediv;
      logic mo_off;
      logic io_on;
      logic [1:0] src;
      logic [5:0] div;
      logic cpu;
      logic [NG-1:0][31:0] gate;
      logic [31:0] rdata;
   } psg_state_t;

   // ---------------------------------------------
   // Address helpers
   // ---------------------------------------------
   function automatic logic in_win(input logic [11:0] a, input logic [11:0] base);
      in_win = (a >= base) && (a < base + 12'(4 * NG)) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic [1:0] gidx(input logic [11:0] a, input logic [11:0] base);
      logic [11:0] d;
      d = a - base;
      gidx = d[3:2];
   endfunction

   psg_state_t s;
   psg_state_t n;
   logic mo_tick;
   logic wr;
   logic hit;
   logic [31:0] rd;
   logic t;
   logic ext;
   logic byp;
   logic pd;
   logic dp;
   logic ag;
   logic [1:0] src;
   logic [1:0] dsrc;
   logic [5:0] dv;
   logic [5:0] dsv;
   logic div_tick_in;
   logic [6:0] divisor;

   // ---------------------------------------------
   // Next state
   // ---------------------------------------------
   always_comb begin
      n = s;
      t = 1'b0;
      wr = psel & penable & pwrite;
      hit = 1'b1;
      rd = 32'h0;
      if (paddr == psg_pkg::OFF_RAW_IRQ) begin
         rd[psg_pkg::LOCK_BIT] = s.locked;
      end else if (paddr == psg_pkg::OFF_IRQ_MASK) begin
         rd[psg_pkg::LOCK_BIT] = s.mask;
      end else if (paddr == psg_pkg::OFF_RUN_CFG) begin
         rd = s.cfg;
      end else if (paddr == psg_pkg::OFF_XLAT) begin
         rd = {24'h0, psg_pkg::psg_pll_mult(s.cfg[psg_pkg::CRYSTAL_LSB +: 4])};
      end else if (paddr == psg_pkg::OFF_RUN_CFG_EXT) begin
         rd = s.cfg_ext;
      end else if (paddr == psg_pkg::OFF_DS_CFG) begin
         rd = s.ds_cfg;
      end else if (in_win(paddr, psg_pkg::OFF_RUN_GATE)) begin
         rd = s.rg[gidx(paddr, psg_pkg::OFF_RUN_GATE)];
      end else if (in_win(paddr, psg_pkg::OFF_SLEEP_GATE)) begin
         rd = s.sg[gidx(paddr, psg_pkg::OFF_SLEEP_GATE)];
      end else if (in_win(paddr, psg_pkg::OFF_DS_GATE)) begin
         rd = s.dg[gidx(paddr, psg_pkg::OFF_DS_GATE)];
      end else begin
         hit = 1'b0;
      end
      if (psel && !penable) begin
         n.rdata = rd;
      end

      // Register writes take effect in the access phase
      if (wr) begin
         if (paddr == psg_pkg::OFF_IRQ_MASK) begin
            n.mask = pwdata[psg_pkg::LOCK_BIT];
         end else if (paddr == psg_pkg::OFF_RUN_CFG) begin
            n.cfg = pwdata;
            t = pwdata[psg_pkg::CRYSTAL_LSB +: 4] != s.cfg[psg_pkg::CRYSTAL_LSB +: 4];
         end else if (paddr == psg_pkg::OFF_RUN_CFG_EXT) begin
            n.cfg_ext = pwdata;
         end else if (paddr == psg_pkg::OFF_DS_CFG) begin
            n.ds_cfg = pwdata;
         end else if (in_win(paddr, psg_pkg::OFF_RUN_GATE)) begin
            n.rg[gidx(paddr, psg_pkg::OFF_RUN_GATE)] = pwdata;
         end else if (in_win(paddr, psg_pkg::OFF_SLEEP_GATE)) begin
            n.sg[gidx(paddr, psg_pkg::OFF_SLEEP_GATE)] = pwdata;
         end else if (in_win(paddr, psg_pkg::OFF_DS_GATE)) begin
            n.dg[gidx(paddr, psg_pkg::OFF_DS_GATE)] = pwdata;
         end
      end

      // Extended configuration overrides the basic bypass, power-down, source and divider fields when enabled
      ext = n.cfg_ext[psg_pkg::USE_EXT_BIT];
      byp = ext ? n.cfg_ext[psg_pkg::BYPASS_BIT] : n.cfg[psg_pkg::BYPASS_BIT];
      pd = ext ? n.cfg_ext[psg_pkg::PWRDN_BIT] : n.cfg[psg_pkg::PWRDN_BIT];
      src = ext ? n.cfg_ext[psg_pkg::OSC_LSB +: 2] : n.cfg[psg_pkg::OSC_LSB +: 2];
      dv = ext ? n.cfg_ext[psg_pkg::DIV_LSB +: 6] : {2'b00, n.cfg[psg_pkg::DIV_LSB +: 4]};
      dsv = n.ds_cfg[psg_pkg::DIV_LSB +: 6];
      dsrc = n.ds_cfg[psg_pkg::OSC_LSB +: 2];
      ag = n.cfg[psg_pkg::AUTOGATE_BIT];

      // Power mode sequencing
      case (s.mode)
         psg_pkg::M_RUN: begin
            if (sleep_req) begin
               n.mode = deep_sel ? psg_pkg::M_DEEP : psg_pkg::M_SLEEP;
               n.ds_pll = ~pd;
            end
         end
         psg_pkg::M_SLEEP: begin
            if (wake_irq) begin
               n.mode = psg_pkg::M_RUN;
            end
         end
         psg_pkg::M_DEEP: begin
            if (wake_irq) begin
               n.mode = psg_pkg::M_WAKE;
            end
         end
         default: begin
            n.mode = psg_pkg::M_RUN;
         end
      endcase
      dp = n.mode == psg_pkg::M_DEEP;

      // Clock tree settings; sleep leaves them untouched
      n.pd = pd | dp;
      n.src = dp ? dsrc : src;
      n.div = dv;
      if (dp && n.ds_pll) begin
         n.div = ext ? dsv : {2'b00, dsv[3:0]};
      end
      n.mo_off = dp && (dsrc != psg_pkg::SRC_MAIN);
      n.io_on = dp && (dsrc == psg_pkg::SRC_INT || dsrc == psg_pkg::SRC_INT4);

      // Relock timer on the main oscillator
      t = t | (s.pd & ~n.pd);
      if (t) begin
         n.relock = RELOCK_COUNT;
      end else if (mo_tick && s.relock != 16'h0) begin
         n.relock = s.relock - 16'h0001;
      end
      n.locked = ~n.pd & ~t & (n.relock == 16'h0);
      n.pll = ~byp & n.locked & ~dp;
      n.usediv = n.cfg[psg_pkg::USEDIV_BIT] | n.pll;

      // Clock gating per mode
      n.cpu = n.mode == psg_pkg::M_RUN;
      case (n.mode)
         psg_pkg::M_RUN: begin
            n.gate = n.rg;
         end
         psg_pkg::M_SLEEP: begin
            n.gate = ag ? n.sg : n.rg;
         end
         default: begin
            n.gate = ag ? n.dg : n.rg;
         end
      endcase
   end

   // ---------------------------------------------
   // State register
   // ---------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.mode <= psg_pkg::M_RUN;
         s.cfg <= psg_pkg::RUN_CFG_RST;
         s.cfg_ext <= psg_pkg::RUN_CFG_EXT_RST;
         s.ds_cfg <= psg_pkg::DS_CFG_RST;
         s.rg[0] <= psg_pkg::GATE0_RST;
         s.sg[0] <= psg_pkg::GATE0_RST;
         s.dg[0] <= psg_pkg::GATE0_RST;
         s.gate[0] <= psg_pkg::GATE0_RST;
         s.pd <= 1'b1;
         s.src <= psg_pkg::SRC_INT;
         s.div <= psg_pkg::RUN_CFG_RST[psg_pkg::DIV_LSB +: 6];
         s.cpu <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // ---------------------------------------------
   // Clock sources and divider
   // ---------------------------------------------
   psg_osc_tick u_mo (
      .clk(pclk),
      .rst_n(presetn),
      .osc_in(main_osc),
      .tick(mo_tick)
   );

   assign div_tick_in = s.pll ? pll_tick : osc_tick[s.src];
   assign divisor = s.usediv ? 7'(s.div) + 7'h01 : 7'h01;

   psg_sys_div_basic u_div (
      .clk(pclk),
      .rst_n(presetn),
      .in_tick(div_tick_in),
      .half(s.pll),
      .divisor(divisor),
      .out_tick(sys_clk_en)
   );

   // ---------------------------------------------
   // Outputs
   // ---------------------------------------------
   assign prdata = s.rdata;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit;
   assign cpu_clk_en = s.cpu;
   assign gate_en = s.gate;
   assign pll_power_down = s.pd;
   assign pll_mult = psg_pkg::psg_pll_mult(s.cfg[psg_pkg::CRYSTAL_LSB +: 4]);
   assign pll_sel = s.pll;
   assign sys_src_sel = s.src;
   assign sys_div_code = s.div;
   assign main_osc_power_down = s.mo_off;
   assign int_osc_power_up = s.io_on;
   assign pll_lock_irq = s.locked & s.mask;

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   a_relock_load: assert property (@(posedge pclk) disable iff (!presetn)
      t |=> (s.relock == RELOCK_COUNT && !s.locked))
      else $error("relock counter not loaded");

   a_pll_unlocked: assert property (@(posedge pclk) disable iff (!presetn)
      (s.relock != 16'h0 || s.pd) |-> !pll_sel)
      else $error("pll selected before settling");

   a_same_crystal: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && paddr == psg_pkg::OFF_RUN_CFG && !ext && pwdata[psg_pkg::PWRDN_BIT] == s.pd && !s.pd
       && pwdata[psg_pkg::CRYSTAL_LSB +: 4] == s.cfg[psg_pkg::CRYSTAL_LSB +: 4]
       && s.mode == psg_pkg::M_RUN && !sleep_req) |=> s.relock <= $past(s.relock))
      else $error("rewrite of same crystal restarted relock");

   a_lock_power: assert property (@(posedge pclk) disable iff (!presetn)
      s.locked |-> (!pll_power_down && s.relock == 16'h0))
      else $error("lock flag while pll down or counting");

   a_sleep_cpu: assert property (@(posedge pclk) disable iff (!presetn)
      (s.mode == psg_pkg::M_SLEEP) |-> (!cpu_clk_en && gate_en == (s.cfg[psg_pkg::AUTOGATE_BIT] ? s.sg : s.rg)))
      else $error("sleep gating wrong");

   a_sleep_clock: assert property (@(posedge pclk) disable iff (!presetn)
      (s.mode == psg_pkg::M_RUN && n.mode == psg_pkg::M_SLEEP && !wr) |=> ($stable(sys_src_sel)
       && $stable(sys_div_code) && $stable(pll_power_down)))
      else $error("sleep changed system clock");

   a_deep_pd: assert property (@(posedge pclk) disable iff (!presetn)
      (s.mode == psg_pkg::M_DEEP) |-> (pll_power_down && !pll_sel && !cpu_clk_en))
      else $error("pll running in deep sleep");

   a_wake_order: assert property (@(posedge pclk) disable iff (!presetn)
      (s.mode == psg_pkg::M_DEEP && wake_irq) |=> (!cpu_clk_en && s.mode == psg_pkg::M_WAKE) ##1 cpu_clk_en)
      else $error("clocks re-enabled before clock restore");

   a_deep_src: assert property (@(posedge pclk) disable iff (!presetn)
      (s.mode == psg_pkg::M_DEEP) |-> (sys_src_sel == s.ds_cfg[psg_pkg::OSC_LSB +: 2]
       && main_osc_power_down == (s.ds_cfg[psg_pkg::OSC_LSB +: 2] != psg_pkg::SRC_MAIN)))
      else $error("deep sleep source wrong");
endmodule
`default_nettype wire

// ==== logic/psg_pkg.sv ====
// Constants and types for the PLL, system clock and sleep gating controller
package psg_pkg;
   // ---------------------------------------------
   // Register byte offsets
   // ---------------------------------------------
   localparam logic [11:0] OFF_RAW_IRQ = 12'h050;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h054;
   localparam logic [11:0] OFF_RUN_CFG = 12'h060;
   localparam logic [11:0] OFF_XLAT = 12'h064;
   localparam logic [11:0] OFF_RUN_CFG_EXT = 12'h070;
   localparam logic [11:0] OFF_RUN_GATE = 12'h100;
   localparam logic [11:0] OFF_SLEEP_GATE = 12'h110;
   localparam logic [11:0] OFF_DS_GATE = 12'h120;
   localparam logic [11:0] OFF_DS_CFG = 12'h144;

   // ---------------------------------------------
   // Field positions
   // ---------------------------------------------
   localparam int OSC_LSB = 4;
   localparam int CRYSTAL_LSB = 6;
   localparam int BYPASS_BIT = 11;
   localparam int PWRDN_BIT = 13;
   localparam int USEDIV_BIT = 22;
   localparam int DIV_LSB = 23;
   localparam int AUTOGATE_BIT = 27;
   localparam int USE_EXT_BIT = 31;
   localparam int LOCK_BIT = 6;

   // ---------------------------------------------
   // Reset values and counts
   // ---------------------------------------------
   localparam logic [31:0] RUN_CFG_RST = 32'h07802ad0;
   localparam logic [31:0] RUN_CFG_EXT_RST = 32'h07802810;
   localparam logic [31:0] DS_CFG_RST = 32'h07800000;
   localparam logic [31:0] GATE0_RST = 32'h00000040;
   localparam logic [15:0] RELOCK_LOAD = 16'h1200;

   // Clock source codes
   localparam logic [1:0] SRC_MAIN = 2'h0;
   localparam logic [1:0] SRC_INT = 2'h1;
   localparam logic [1:0] SRC_INT4 = 2'h2;

   typedef enum logic [1:0] {M_RUN, M_SLEEP, M_DEEP, M_WAKE} psg_mode_t;

   // VCO multiplier per crystal code, rounded toward 400 MHz; zero for codes below the PLL range
   function automatic logic [7:0] psg_pll_mult(input logic [3:0] code);
      case (code)
         4'h4: psg_pll_mult = 8'h70;
         4'h5: psg_pll_mult = 8'h6d;
         4'h6: psg_pll_mult = 8'h64;
         4'h7: psg_pll_mult = 8'h62;
         4'h8: psg_pll_mult = 8'h51;
         4'h9: psg_pll_mult = 8'h50;
         4'ha: psg_pll_mult = 8'h4e;
         4'hb: psg_pll_mult = 8'h43;
         4'hc: psg_pll_mult = 8'h41;
         4'hd: psg_pll_mult = 8'h36;
         4'he: psg_pll_mult = 8'h32;
         4'hf: psg_pll_mult = 8'h31;
         default: psg_pll_mult = 8'h00;
      endcase
   endfunction
endpackage

// ==== logic/psg_osc_tick.sv ====
// Main oscillator pin synchroniser producing one pclk-wide tick per rising edge
`timescale 1ns/1ns
`default_nettype none
module psg_osc_tick (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic osc_in,
   output logic tick
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic tick;
   } psg_tick_t;

   psg_tick_t s;
   psg_tick_t n;

   always_comb begin
      n = s;
      n.s1 = osc_in;
      n.s2 = s.s1;
      n.s3 = s.s2;
      n.tick = s.s2 & ~s.s3;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign tick = s.tick;
endmodule
`default_nettype wire

// ==== logic/psg_sys_div_basic.sv ====
// System clock divider: optional halving stage, then divide by a programmable count
`timescale 1ns/1ns
`default_nettype none
module psg_sys_div_basic (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_tick,
   input wire logic half,
   input wire logic [6:0] divisor,
   output logic out_tick
);
   typedef struct packed {
      logic ph;
      logic [6:0] cnt;
      logic tick;
   } psg_div_t;

   psg_div_t s;
   psg_div_t n;

   always_comb begin
      n = s;
      n.tick = 1'b0;
      if (in_tick) begin
         if (half && !s.ph) begin
            n.ph = 1'b1;
         end else begin
            n.ph = 1'b0;
            if (s.cnt + 7'h01 >= divisor) begin
               n.cnt = 7'h00;
               n.tick = 1'b1;
            end else begin
               n.cnt = s.cnt + 7'h01;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign out_tick = s.tick;

   a_div_by_one: assert property (@(posedge clk) disable iff (!rst_n)
      (in_tick && !half && divisor == 7'h01) |=> out_tick)
      else $error("divide by one missed a tick");
endmodule
`default_nettype wire

// ==== verif/psg_core_model.sv ====
// Core, oscillator and PLL output model facing the clock controller
`timescale 1ns/1ns
`default_nettype none
module psg_core_model (
   input wire logic pclk,
   input wire logic pll_power_down,
   output logic main_osc,
   output logic [3:0] osc_tick,
   output logic pll_tick,
   output logic sleep_req,
   output logic deep_sel,
   output logic wake_irq
);
   logic [2:0] ph = 3'h0;
   initial begin
      main_osc = 1'b0;
      osc_tick = 4'h0;
      pll_tick = 1'b0;
      sleep_req = 1'b0;
      deep_sel = 1'b0;
      wake_irq = 1'b0;
   end
   // ---------------------------------------------
   // Oscillators
   // ---------------------------------------------
   // Main oscillator runs from time zero, period six cycles
   always @(posedge pclk) begin
      ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
      if (ph == 3'h2 || ph == 3'h5) begin
         main_osc <= ~main_osc;
      end
      osc_tick <= {4{ph[0]}};
      pll_tick <= ~pll_power_down;
   end
   // ---------------------------------------------
   // Core requests
   // ---------------------------------------------
   task automatic wait_interrupt_instr(input logic deep);
      @(posedge pclk);
      sleep_req <= 1'b1;
      deep_sel <= deep;
      @(posedge pclk);
      sleep_req <= 1'b0;
   endtask
   task automatic wake();
      @(posedge pclk);
      wake_irq <= 1'b1;
      @(posedge pclk);
      wake_irq <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== verif/tb_psg_top.sv ====
// Self-checking testbench for the clock controller
`timescale 1ns/1ns
`default_nettype none
module tb_psg_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, main_osc, pll_tick, sleep_req, deep_sel, wake_irq;
   logic [3:0] osc_tick;
   logic sys_clk_en, cpu_clk_en, pll_power_down, pll_sel, main_osc_power_down, int_osc_power_up, pll_lock_irq;
   logic [95:0] gate_en;
   logic [7:0] pll_mult;
   logic [1:0] sys_src_sel;
   logic [5:0] sys_div_code;
   logic [31:0] rq;
   logic re;
   int err_total = 0;
   int num_checks = 0;
   always #50 pclk = ~pclk;
   psg_core_model core (.pclk(pclk), .pll_power_down(pll_power_down), .main_osc(main_osc),
      .osc_tick(osc_tick), .pll_tick(pll_tick), .sleep_req(sleep_req), .deep_sel(deep_sel), .wake_irq(wake_irq));
   psg_top #(.NG(3), .RELOCK_COUNT(16'h0008)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .main_osc(main_osc), .osc_tick(osc_tick), .pll_tick(pll_tick), .sleep_req(sleep_req),
      .deep_sel(deep_sel), .wake_irq(wake_irq), .sys_clk_en(sys_clk_en), .cpu_clk_en(cpu_clk_en),
      .gate_en(gate_en), .pll_power_down(pll_power_down), .pll_mult(pll_mult), .pll_sel(pll_sel),
      .sys_src_sel(sys_src_sel), .sys_div_code(sys_div_code), .main_osc_power_down(main_osc_power_down),
      .int_osc_power_up(int_osc_power_up), .pll_lock_irq(pll_lock_irq));
   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h00000000);
      chk(nm, e, rq);
   endtask
   // Counts system clock pulses over n cycles, one pulse of slack for phase
   task automatic rate(input string nm, input int n, input int e);
      int c = 0;
      repeat (n) begin
         @(negedge pclk);
         if (sys_clk_en === 1'b1) c++;
      end
      num_checks++;
      if (c < e - 1 || c > e + 1) begin
         err_total++;
         $display("Error %s expected %0d seen %0d", nm, e, c);
      end
   endtask
   task automatic lockwait();
      int k = 0;
      rq = 32'h00000000;
      while (rq[6] !== 1'b1 && k < 60) begin
         apb(1'b0, psg_pkg::OFF_RAW_IRQ, 32'h00000000);
         k++;
      end
      chk("lock flag", 32'h00000040, rq);
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_reset();
      @(negedge pclk);
      chk("pll_power_down", 32'h1, {31'h0, pll_power_down});
      chk("pll_sel", 32'h0, {31'h0, pll_sel});
      chk("cpu_clk_en", 32'h1, {31'h0, cpu_clk_en});
      chk("gate0", 32'h00000040, gate_en[31:0]);
      chk("pready", 32'h1, {31'h0, pready});
      rd("run cfg", psg_pkg::OFF_RUN_CFG, psg_pkg::RUN_CFG_RST);
      rd("ext cfg", psg_pkg::OFF_RUN_CFG_EXT, psg_pkg::RUN_CFG_EXT_RST);
      rd("deep cfg", psg_pkg::OFF_DS_CFG, psg_pkg::DS_CFG_RST);
      rd("sleep gate0", psg_pkg::OFF_SLEEP_GATE, psg_pkg::GATE0_RST);
      rd("run gate1", psg_pkg::OFF_RUN_GATE + 12'h004, 32'h00000000);
      rd("raw status", psg_pkg::OFF_RAW_IRQ, 32'h00000000);
   endtask
   task automatic t_bus();
      rd("unmapped data", 12'hffc, 32'h00000000);
      chk("unmapped err", 32'h1, {31'h0, re});
      wr(psg_pkg::OFF_XLAT, 32'hffffffff);
      chk("xlat write err", 32'h0, {31'h0, re});
      apb(1'b0, psg_pkg::OFF_XLAT, 32'h00000000);
      chk("xlat", 32'h00000043, {24'h0, rq[7:0]});
   endtask
   task automatic t_divide();
      wr(psg_pkg::OFF_RUN_CFG, 32'h00002980);
      rate("bypass rate", 800, 400);
      wr(psg_pkg::OFF_RUN_CFG, 32'h00402980);
      wr(psg_pkg::OFF_RUN_CFG_EXT, 32'h9f802800);
      repeat (10) @(negedge pclk);
      chk("wide div code", 32'h3f, {26'h0, sys_div_code});
      rate("wide rate", 1280, 10);
      wr(psg_pkg::OFF_RUN_CFG_EXT, psg_pkg::RUN_CFG_EXT_RST);
   endtask
   task automatic t_relock();
      wr(psg_pkg::OFF_IRQ_MASK, 32'h00000040);
      wr(psg_pkg::OFF_RUN_CFG, 32'h01c00180);
      @(negedge pclk);
      chk("pll normal", 32'h0, {31'h0, pll_power_down});
      chk("pll_mult", 32'h64, {24'h0, pll_mult});
      repeat (20) @(negedge pclk);
      chk("pll_sel early", 32'h0, {31'h0, pll_sel});
      lockwait();
      @(negedge pclk);
      chk("pll_sel locked", 32'h1, {31'h0, pll_sel});
      chk("lock irq", 32'h1, {31'h0, pll_lock_irq});
      rate("pll rate", 800, 100);
      wr(psg_pkg::OFF_RUN_CFG, 32'h01c00180);
      rd("same crystal", psg_pkg::OFF_RAW_IRQ, 32'h00000040);
      wr(psg_pkg::OFF_RUN_CFG, 32'h01c001c0);
      rd("new crystal", psg_pkg::OFF_RAW_IRQ, 32'h00000000);
      lockwait();
   endtask
   task automatic t_sleep();
      wr(psg_pkg::OFF_RUN_GATE, 32'h00000003);
      wr(psg_pkg::OFF_RUN_GATE + 12'h004, 32'h00000a5a);
      wr(psg_pkg::OFF_SLEEP_GATE, 32'h00000005);
      wr(psg_pkg::OFF_RUN_CFG, 32'h09c001c0);
      @(negedge pclk);
      chk("run gate1", 32'h00000a5a, gate_en[63:32]);
      core.wait_interrupt_instr(1'b0);
      @(negedge pclk);
      chk("sleep cpu", 32'h0, {31'h0, cpu_clk_en});
      chk("sleep gate", 32'h5, gate_en[31:0]);
      chk("sleep div", 32'h3, {26'h0, sys_div_code});
      rate("sleep rate", 800, 100);
      core.wake();
      @(negedge pclk);
      chk("run cpu", 32'h1, {31'h0, cpu_clk_en});
      chk("run gate", 32'h3, gate_en[31:0]);
      wr(psg_pkg::OFF_RUN_CFG, 32'h01c001c0);
      core.wait_interrupt_instr(1'b0);
      @(negedge pclk);
      chk("no auto gate", 32'h3, gate_en[31:0]);
      core.wake();
   endtask
   task automatic t_deep();
      wr(psg_pkg::OFF_DS_GATE, 32'h00000009);
      wr(psg_pkg::OFF_DS_CFG, 32'h02800010);
      wr(psg_pkg::OFF_RUN_CFG, 32'h09c001c0);
      core.wait_interrupt_instr(1'b1);
      @(negedge pclk);
      chk("deep cpu", 32'h0, {31'h0, cpu_clk_en});
      chk("deep src", 32'h1, {30'h0, sys_src_sel});
      chk("deep gate", 32'h9, gate_en[31:0]);
      chk("deep pll off", 32'h1, {31'h0, pll_power_down});
      chk("deep div", 32'h5, {26'h0, sys_div_code});
      chk("int osc up", 32'h1, {31'h0, int_osc_power_up});
      chk("main osc down", 32'h1, {31'h0, main_osc_power_down});
      core.wake();
      @(negedge pclk);
      chk("wake div", 32'h3, {26'h0, sys_div_code});
      chk("wake src", 32'h0, {30'h0, sys_src_sel});
      chk("wake pll on", 32'h0, {31'h0, pll_power_down});
      chk("wake cpu held", 32'h0, {31'h0, cpu_clk_en});
      @(negedge pclk);
      chk("wake cpu", 32'h1, {31'h0, cpu_clk_en});
      chk("wake gate", 32'h3, gate_en[31:0]);
      chk("wake relock", 32'h0, {31'h0, pll_sel});
      lockwait();
      // Deep sleep with the PLL already off keeps the run divider
      wr(psg_pkg::OFF_RUN_CFG, 32'h09c029c0);
      wr(psg_pkg::OFF_DS_CFG, 32'h02800020);
      core.wait_interrupt_instr(1'b1);
      @(negedge pclk);
      chk("deep no override", 32'h3, {26'h0, sys_div_code});
      chk("deep src int4", 32'h2, {30'h0, sys_src_sel});
      chk("int4 osc up", 32'h1, {31'h0, int_osc_power_up});
      core.wake();
      @(negedge pclk);
      chk("wake src main", 32'h0, {30'h0, sys_src_sel});
      @(negedge pclk);
      chk("wake cpu again", 32'h1, {31'h0, cpu_clk_en});
   endtask
   // ---------------------------------------------
   // Run control
   // ---------------------------------------------
   task automatic close_out();
      $display("Checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge pclk);
      err_total++;
      $display("Error watchdog expired");
      close_out();
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_bus();
      t_divide();
      t_relock();
      t_sleep();
      t_deep();
      close_out();
   end
endmodule
`default_nettype wire
